// ### hdl/silp_defines.vh
// silp_defines.vh: offsets, field positions, reset values and timing
// counts for the system integration low-power status block.
// assumes inclusion by bare name from the design file.
`ifndef SILP_DEFINES_VH
`define SILP_DEFINES_VH

// register word indices; the bus byte address is four times the index
`define SILP_ADDR_W 18
`define SILP_OFF_BREAK_WAKE 16'hFE00
`define SILP_OFF_RESET_CAUSE 16'hFE01
`define SILP_OFF_BREAK_CTRL 16'hFE03
`define SILP_OFF_PEND_A 16'hFE04
`define SILP_OFF_PEND_B 16'hFE05
`define SILP_OFF_PEND_C 16'hFE08
`define SILP_OFF_LP_CTRL 16'hFE0C
`define SILP_OFF_LP_STAT 16'hFE10

// field positions
`define SILP_BIT_BREAK_WAKE 1
`define SILP_BIT_CLEAR_EN 7
`define SILP_BIT_POR 7
`define SILP_BIT_PIN 6
`define SILP_BIT_WDOG 5
`define SILP_BIT_BADOP 4
`define SILP_BIT_BADAD 3
`define SILP_BIT_LVI 1
`define SILP_BIT_SHORT_REC 0
`define SILP_BIT_WDOG_DIS 1

// reset values
`define SILP_RST_CAUSE 8'h80
`define SILP_RST_ZERO8 8'h00

// axi responses
`define SILP_RESP_OKAY 2'h0
`define SILP_RESP_SLVERR 2'h2

// stop recovery lengths in internal oscillator cycles
`define SILP_REC_LONG 13'h1000
`define SILP_REC_SHORT 13'h0020

// low-power state codes
`define SILP_ST_RUN 2'h0
`define SILP_ST_WAIT 2'h1
`define SILP_ST_STOP 2'h2
`define SILP_ST_REC 2'h3

`endif

// ### hdl/silp_core.v
// silp_core.v: system integration logic with status registers,
// break-state control, wait/stop sequencing and stop recovery timing.
// assumes a single bus clock, synchronous active-low reset, and that
// the cpu and peripherals sit on the internal side of these ports.
`timescale 1ns/1ns
`include "silp_defines.vh"

////////////////////////////////////////////////////////////////////////
// Overview of operation
// - pending flags for sources 14..7 read at bits 7..0 of status b.
// - pending flags for sources 17..15 read in status c.
// - any reset source wins over all interrupts, no arbitration.
// - break request forces the cpu to the software interrupt vector.
// - in break with clear enable low, peripheral flag clears are blocked.
// - with clear enable set, flags clear in break and stay cleared.
// - two-step clears stay blocked in break; second step after clears.
// - wait or stop clears the cpu interrupt mask; cpu held unclocked.
// - wait gates cpu clocks off, peripheral clocks keep running.
// - enabled interrupt wakes wait; stacking starts one cycle later.
// - wait also ends on reset or break.
// - watchdog runs during wait while its disable option is 0.
// - stop clears the internal counter and disables clock output.
// - stop ends on interrupt, reset or break; recovery precedes stacking.
// - recovery is 4096 oscillator cycles, or 32 with short select.
// - counter held cleared in stop, then times the recovery.
// - break wake flag sets on break exit; write 0 or reset clears.
// - break status fe00, reset status fe01, break control fe03.
// - reading reset status clears it; power-on sets bit 7 only.
// - reset causes latched at bits 6,5,4,3,1; bits 2 and 0 read 0.
// - break clear enable is bit 7 of control, read/write, reset 0.
// - status a holds sources 6..1 at bits 7..2, bits 1..0 read 0.
module silp_core #(
   parameter REC_LONG = 4096,
   parameter REC_SHORT = 32
) (
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [`SILP_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`SILP_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // reset cause pulses, one cycle before or with the reset
   input wire power_on_reset,
   input wire pin_reset,
   input wire watchdog_reset,
   input wire bad_opcode_reset,
   input wire bad_fetch_address_reset,
   input wire low_voltage_reset,
   // interrupt and break requests
   input wire [17:1] pending_irq,
   input wire enabled_irq,
   input wire break_request,
   // cpu low-power instruction strobes
   input wire wait_instr,
   input wire stop_instr,
   input wire internal_oscillator_clock_tick,
   // cpu side controls
   output reg cpu_clock_enable,
   output reg peripheral_clock_enable,
   output reg clock_generator_output_enable,
   output reg clear_interrupt_mask,
   output reg start_stacking,
   output reg force_software_interrupt_vector,
   output wire reset_override,
   output wire in_break,
   output wire flag_clear_permit,
   output wire watchdog_run,
   output reg [12:0] internal_counter
);

   ////////////////////////////////////////////////////////////////////
   // state and registers
   reg [1:0] lp_state;
   reg [1:0] next_lp_state;
   reg break_wake_flag;
   reg [7:0] reset_cause_status;
   reg break_clear_enable;
   reg short_stop_recovery_select;
   reg watchdog_disable_option;
   reg break_active;
   reg wake_pending;
   reg aw_held;
   reg w_held;
   reg [`SILP_ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   wire any_reset;
   wire [12:0] rec_len;
   wire do_write;
   wire do_read;
   wire [`SILP_ADDR_W-3:0] aw_idx;
   wire [`SILP_ADDR_W-3:0] ar_idx;
   wire [7:0] pending_irq_status_a;
   wire [7:0] pending_irq_status_b;
   wire [7:0] pending_irq_status_c;

   // reset sources share one top priority, no arbitration
   assign any_reset = power_on_reset | pin_reset | watchdog_reset |
      bad_opcode_reset | bad_fetch_address_reset | low_voltage_reset;
   assign reset_override = any_reset;

   // upper bits of status c are tied to zero, writes are ignored
   // live pending flags, not latched
   assign pending_irq_status_a = {pending_irq[6:1], 2'h0};
   assign pending_irq_status_b = pending_irq[14:7];
   assign pending_irq_status_c = {5'h00, pending_irq[17:15]};

   // flag clearing in peripherals blocked in break unless enabled
   assign in_break = break_active;
   assign flag_clear_permit = ~break_active | break_clear_enable;

   // the watchdog stops with the clocks in stop and recovery
   // watchdog keeps running in wait when not disabled
   assign watchdog_run = ~watchdog_disable_option &
      (lp_state != `SILP_ST_STOP) & (lp_state != `SILP_ST_REC);

   // parameters are cut to the counter width on purpose
   // recovery length selection
   assign rec_len = short_stop_recovery_select ? REC_SHORT[12:0] :
      REC_LONG[12:0];

   ////////////////////////////////////////////////////////////////////
   // axi4-lite handshake: address and data taken in either order
   // one write and one read at a time: ready drops while a response waits
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   assign do_read = s_axi_arvalid & ~s_axi_rvalid;

   // register index is the byte address over four; the low bits are
   // ignored, so any byte inside a word selects that register
   assign aw_idx = aw_addr[`SILP_ADDR_W-1:2];
   assign ar_idx = s_axi_araddr[`SILP_ADDR_W-1:2];

   // capture write address and data; each half waits here for the
   // other, so the master may offer them in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`SILP_ADDR_W{1'b0}};
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // write response
   // unmapped words answer slverr; read-only words take writes silently
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SILP_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         case (aw_idx)
            `SILP_OFF_BREAK_WAKE, `SILP_OFF_RESET_CAUSE,
            `SILP_OFF_BREAK_CTRL, `SILP_OFF_PEND_A, `SILP_OFF_PEND_B,
            `SILP_OFF_PEND_C, `SILP_OFF_LP_CTRL, `SILP_OFF_LP_STAT:
               s_axi_bresp <= `SILP_RESP_OKAY;
            default:
               s_axi_bresp <= `SILP_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read data mux, one register per word
   // rdata and rresp hold with rvalid until rready is seen
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SILP_RESP_OKAY;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SILP_RESP_OKAY;
         case (ar_idx)
            `SILP_OFF_BREAK_WAKE:
               s_axi_rdata <= {30'h00000000, break_wake_flag,
                  1'b0};
            `SILP_OFF_RESET_CAUSE:
               s_axi_rdata <= {24'h000000, reset_cause_status};
            `SILP_OFF_BREAK_CTRL:
               s_axi_rdata <= {24'h000000, break_clear_enable,
                  7'h00};
            `SILP_OFF_PEND_A:
               s_axi_rdata <= {24'h000000, pending_irq_status_a};
            `SILP_OFF_PEND_B:
               s_axi_rdata <= {24'h000000, pending_irq_status_b};
            `SILP_OFF_PEND_C:
               s_axi_rdata <= {24'h000000, pending_irq_status_c};
            `SILP_OFF_LP_CTRL:
               s_axi_rdata <= {30'h00000000, watchdog_disable_option,
                  short_stop_recovery_select};
            `SILP_OFF_LP_STAT:
               s_axi_rdata <= {16'h0000, break_active, lp_state,
                  internal_counter};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `SILP_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reset cause register: latched causes, cleared by read
   // power-on outranks the other causes and restarts the register
   always @(posedge aclk) begin
      if (!aresetn) begin
         reset_cause_status <= `SILP_RST_CAUSE;
      end else if (power_on_reset) begin
         reset_cause_status <= `SILP_RST_CAUSE;
      end else if (any_reset) begin
         // cause of the last reset wins over a same-cycle read
         reset_cause_status <= {1'b0, pin_reset, watchdog_reset,
            bad_opcode_reset, bad_fetch_address_reset, 1'b0,
            low_voltage_reset, 1'b0};
      end else if (do_read && ar_idx == `SILP_OFF_RESET_CAUSE) begin
         reset_cause_status <= `SILP_RST_ZERO8;
      end
   end

   // software control bits
   // each control bit is written only through its own byte lane
   always @(posedge aclk) begin
      if (!aresetn) begin
         break_clear_enable <= 1'b0;
         short_stop_recovery_select <= 1'b0;
         watchdog_disable_option <= 1'b0;
      end else if (do_write) begin
         if (aw_idx == `SILP_OFF_BREAK_CTRL && w_strb[0])
            break_clear_enable <= w_data[`SILP_BIT_CLEAR_EN];
         if (aw_idx == `SILP_OFF_LP_CTRL && w_strb[0]) begin
            short_stop_recovery_select <= w_data[`SILP_BIT_SHORT_REC];
            watchdog_disable_option <= w_data[`SILP_BIT_WDOG_DIS];
         end
      end
   end

   // break wake flag: set wins over a write of 0
   // only a break in wait, stop or stop recovery sets the flag
   always @(posedge aclk) begin
      if (!aresetn || any_reset) begin
         break_wake_flag <= 1'b0;
      end else if (break_request && lp_state != `SILP_ST_RUN) begin
         break_wake_flag <= 1'b1;
      end else if (do_write && aw_idx == `SILP_OFF_BREAK_WAKE &&
            w_strb[0] && !w_data[`SILP_BIT_BREAK_WAKE]) begin
         break_wake_flag <= 1'b0;
      end
   end

   // break state follows the break request one cycle late; the
   // vector force is a single pulse on the first break cycle, and
   // peripherals see the protection through flag_clear_permit
   always @(posedge aclk) begin
      if (!aresetn || any_reset) begin
         break_active <= 1'b0;
         force_software_interrupt_vector <= 1'b0;
      end else begin
         break_active <= break_request;
         force_software_interrupt_vector <= break_request &
            ~break_active;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // low-power sequencer next state
   // break leaves stop at once; an interrupt goes through recovery
   // first so that the oscillator can settle before stacking
   always @* begin
      next_lp_state = lp_state;
      case (lp_state)
         `SILP_ST_RUN: begin
            if (stop_instr)
               next_lp_state = `SILP_ST_STOP;
            else if (wait_instr)
               next_lp_state = `SILP_ST_WAIT;
         end
         `SILP_ST_WAIT: begin
            if (enabled_irq || break_request)
               next_lp_state = `SILP_ST_RUN;
         end
         `SILP_ST_STOP: begin
            if (break_request)
               next_lp_state = `SILP_ST_RUN;
            else if (enabled_irq)
               next_lp_state = `SILP_ST_REC;
         end
         `SILP_ST_REC: begin
            if (internal_counter >= rec_len - 13'h0001 &&
                  internal_oscillator_clock_tick)
               next_lp_state = `SILP_ST_RUN;
         end
         default: next_lp_state = `SILP_ST_RUN;
      endcase
   end

   // sequencer registers and clock gating
   // clock enables are registered from the next state, so they turn
   // together with the state rather than a cycle after it
   always @(posedge aclk) begin
      if (!aresetn || any_reset) begin
         lp_state <= `SILP_ST_RUN;
         cpu_clock_enable <= 1'b1;
         peripheral_clock_enable <= 1'b1;
         clock_generator_output_enable <= 1'b1;
         clear_interrupt_mask <= 1'b0;
         start_stacking <= 1'b0;
         wake_pending <= 1'b0;
      end else begin
         lp_state <= next_lp_state;
         // both low-power instructions clear the mask
         clear_interrupt_mask <= (lp_state == `SILP_ST_RUN) &
            (wait_instr | stop_instr);
         cpu_clock_enable <= (next_lp_state == `SILP_ST_RUN);
         peripheral_clock_enable <=
            (next_lp_state == `SILP_ST_RUN) |
            (next_lp_state == `SILP_ST_WAIT);
         clock_generator_output_enable <=
            (next_lp_state != `SILP_ST_STOP);
         // stacking one cycle after interrupt wakes from wait
         wake_pending <= (lp_state == `SILP_ST_WAIT) & enabled_irq &
            ~break_request;
         start_stacking <= wake_pending |
            ((lp_state == `SILP_ST_REC) &&
            (next_lp_state == `SILP_ST_RUN));
      end
   end

   // internal counter: cleared through stop, counts the recovery
   // free running elsewhere; only the span after stop is timed
   // the 13-bit width covers the long recovery with room to spare
   always @(posedge aclk) begin
      if (!aresetn) begin
         internal_counter <= 13'h0000;
      end else if (lp_state == `SILP_ST_STOP) begin
         internal_counter <= 13'h0000;
      end else if (internal_oscillator_clock_tick) begin
         internal_counter <= internal_counter + 13'h0001;
      end
   end

endmodule

// ### bench/silp_core_asserts.sv
// silp_core_asserts.sv: port-level checks of sequencer and break control.
// assumes binding onto silp_core, one clock, sync active-low reset.
`timescale 1ns/1ns
module silp_core_chk (
   input wire aclk,
   input wire aresetn,
   input wire power_on_reset,
   input wire pin_reset,
   input wire watchdog_reset,
   input wire bad_opcode_reset,
   input wire bad_fetch_address_reset,
   input wire low_voltage_reset,
   input wire enabled_irq,
   input wire break_request,
   input wire wait_instr,
   input wire stop_instr,
   input wire cpu_clock_enable,
   input wire peripheral_clock_enable,
   input wire clock_generator_output_enable,
   input wire clear_interrupt_mask,
   input wire start_stacking,
   input wire force_software_interrupt_vector,
   input wire reset_override,
   input wire in_break,
   input wire flag_clear_permit,
   input wire [12:0] internal_counter
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // any reset source at all
   wire any_rst = power_on_reset | pin_reset | watchdog_reset |
      bad_opcode_reset | bad_fetch_address_reset | low_voltage_reset;
   // running with no wake cause pending
   sequence run_s;
      cpu_clock_enable && clock_generator_output_enable && !any_rst &&
         !break_request && !enabled_irq;
   endsequence
   // cpu stopped, peripherals alive
   sequence wait_s;
      !cpu_clock_enable && peripheral_clock_enable;
   endsequence
   ////////////////////////////////////////////////////////////////////
   reset_ovr_a: assert property (reset_override == any_rst)
      else $error("reset override not the or of sources");
   vector_force_a: assert property ($rose(break_request) && !any_rst
      |=> force_software_interrupt_vector)
      else $error("break did not force the vector");
   break_track_a: assert property (break_request && !any_rst
      |=> in_break)
      else $error("break state not entered");
   clear_permit_a: assert property (!in_break |-> flag_clear_permit)
      else $error("flag clear blocked outside break");
   mask_clear_a: assert property (run_s ##0 (wait_instr || stop_instr)
      |=> clear_interrupt_mask)
      else $error("mask not cleared by low-power entry");
   wait_gate_a: assert property (run_s ##0 wait_instr
      |=> ##[0:1] wait_s)
      else $error("wait did not gate cpu clock only");
   wait_wake_a: assert property (wait_s ##0 $rose(enabled_irq) &&
      !any_rst && !break_request |-> ##[1:2] start_stacking)
      else $error("wait wake stacking late");
   stop_entry_a: assert property (run_s ##0 stop_instr
      |=> ##[0:1] !clock_generator_output_enable &&
      internal_counter == 13'h0000)
      else $error("stop entry did not halt clocks and counter");
endmodule
bind silp_core silp_core_chk silp_core_chk_inst (.*);

// ### bench/silp_cpu_model.sv
// silp_cpu_model.sv: behavioural cpu and peripheral side of the block.
// assumes the bench requests strobes for one cycle at a time.
`timescale 1ns/1ns
module silp_cpu_model (
   input wire aclk,
   input wire aresetn,
   input wire req_wait,
   input wire req_stop,
   input wire req_irq,
   input wire start_stacking,
   output reg wait_instr,
   output reg stop_instr,
   output reg enabled_irq,
   output reg internal_oscillator_clock_tick
);
   // strobes, oscillator ticks, irq held until stacking takes it
   always @(posedge aclk) begin
      if (!aresetn) begin
         wait_instr <= 1'h0;
         stop_instr <= 1'h0;
         enabled_irq <= 1'h0;
         internal_oscillator_clock_tick <= 1'h0;
      end else begin
         wait_instr <= req_wait;
         stop_instr <= req_stop;
         internal_oscillator_clock_tick <= ~internal_oscillator_clock_tick;
         if (req_irq) begin
            enabled_irq <= 1'h1;
         end else if (start_stacking) begin
            enabled_irq <= 1'h0;
         end
      end
   end
endmodule

// ### bench/silp_core_tb.sv
// silp_core_tb.sv: self-checking bench driving registers and sequencing.
// assumes silp_core, silp_cpu_model and the checker are compiled first.
`timescale 1ns/1ns
`include "silp_defines.vh"
module silp_core_tb;
   localparam REC_L = 64;
   localparam REC_S = 8;
   reg aclk = 1'h0, aresetn = 1'h0;
   reg [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'h0;
   reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, break_request = 1'h0;
   reg power_on_reset = 1'h0, pin_reset = 1'h0, watchdog_reset = 1'h0;
   reg bad_opcode_reset = 1'h0, bad_fetch_address_reset = 1'h0;
   reg low_voltage_reset = 1'h0, req_wait = 1'h0, req_stop = 1'h0;
   reg req_irq = 1'h0;
   reg [17:1] pending_irq = 17'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, wait_instr, stop_instr, enabled_irq;
   wire internal_oscillator_clock_tick, cpu_clock_enable, start_stacking;
   wire peripheral_clock_enable, clock_generator_output_enable;
   wire clear_interrupt_mask, force_software_interrupt_vector;
   wire reset_override, in_break, flag_clear_permit, watchdog_run;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [12:0] internal_counter;
   reg [31:0] d, e;
   reg [1:0] r;
   integer failures = 0, compares = 0, i, n, seed;
   silp_core #(.REC_LONG(REC_L), .REC_SHORT(REC_S)) silp_core_inst (.*);
   silp_cpu_model silp_cpu_model_inst (.*);
   // bus clock, 50 ns period
   always #25 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////
   function [7:0] cause_exp(input integer k);
      cause_exp = (k == 5) ? 8'h02 : (8'h80 >> k);
   endfunction
   function [15:0] pend_ab(input [17:1] p);
      pend_ab = {p[14:7], p[6:1], 2'h0};
   endfunction
   // byte address of a register word index
   function [17:0] ba(input [15:0] x);
      ba = {x, 2'h0};
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk_rng(input integer k, input integer lo, input integer hi);
      begin
         compares = compares + 1;
         if (k < lo || k > hi) begin
            failures = failures + 1;
            $display("[ERR] %0t count %0d out of range", $time, k);
         end
      end
   endtask
   // axi4-lite write, address and data offered together
   task wr(input [17:0] a, input [31:0] v, input [3:0] s);
      reg ta, tw, tb;
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         tb = 1'h0;
         while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
         end
         s_axi_bready <= 1'h0;
      end
   endtask
   // axi4-lite read, data and response taken with rvalid
   task rd(input [17:0] a, output [31:0] v, output [1:0] rs);
      reg ta, t;
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         t = 1'h0;
         while (!t) begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            t = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
         end
         s_axi_rready <= 1'h0;
      end
   endtask
   // count cycles until stacking starts
   task wait_stack;
      begin
         n = 0;
         while (start_stacking !== 1'h1) begin
            @(negedge aclk);
            n = n + 1;
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // watchdog on a hung run
   initial begin
      #200000;
      failures = failures + 1;
      wrap_up;
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(32'h983D);
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(ba(`SILP_OFF_RESET_CAUSE), d, r);
      chk(d, `SILP_RST_CAUSE);
      rd(ba(`SILP_OFF_BREAK_CTRL), d, r);
      chk(d, 32'h0);
      rd(ba(`SILP_OFF_RESET_CAUSE), d, r);
      chk(d, 32'h0);
      wr(ba(`SILP_OFF_BREAK_CTRL), 32'h80, 4'h1);
      rd(ba(`SILP_OFF_BREAK_CTRL), d, r);
      chk(d, 32'h80);
      rd(ba(16'hFE20), d, r);
      chk(d, 32'h0);
      chk(r, `SILP_RESP_SLVERR);
      $display("register test done");
      for (i = 0; i < 6; i = i + 1) begin
         @(posedge aclk);
         {low_voltage_reset, bad_fetch_address_reset, bad_opcode_reset,
            watchdog_reset, pin_reset, power_on_reset} <= 6'h01 << i;
         @(posedge aclk);
         {low_voltage_reset, bad_fetch_address_reset, bad_opcode_reset,
            watchdog_reset, pin_reset, power_on_reset} <= 6'h00;
         rd(ba(`SILP_OFF_RESET_CAUSE), d, r);
         chk(d, cause_exp(i));
      end
      $display("reset cause test done");
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge aclk);
         pending_irq <= (i == 0) ? 17'h1FFFF : $urandom;
         rd(ba(`SILP_OFF_PEND_A), d, r);
         rd(ba(`SILP_OFF_PEND_B), e, r);
         chk({e[23:0], d[7:0]}, pend_ab(pending_irq));
         rd(ba(`SILP_OFF_PEND_C), d, r);
         chk(d, {5'h00, pending_irq[17:15]});
      end
      $display("pending flag test done");
      @(posedge aclk);
      req_wait <= 1'h1;
      @(posedge aclk);
      req_wait <= 1'h0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(cpu_clock_enable, 1'h0);
      chk(watchdog_run, 1'h1);
      // break from wait with clear enable set, then from run without
      for (i = 0; i < 2; i = i + 1) begin
         @(posedge aclk);
         break_request <= 1'h1;
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         chk(in_break, 1'h1);
         chk(flag_clear_permit, !i);
         @(posedge aclk);
         break_request <= 1'h0;
         rd(ba(`SILP_OFF_BREAK_WAKE), d, r);
         chk(d, !i ? 32'h2 : 32'h0);
         wr(ba(`SILP_OFF_BREAK_WAKE), 32'h0, 4'h1);
         wr(ba(`SILP_OFF_BREAK_CTRL), 32'h0, 4'h1);
      end
      rd(ba(`SILP_OFF_BREAK_WAKE), d, r);
      chk(d, 32'h0);
      @(posedge aclk);
      req_wait <= 1'h1;
      @(posedge aclk);
      req_wait <= 1'h0;
      repeat (3) @(posedge aclk);
      req_irq <= 1'h1;
      @(posedge aclk);
      req_irq <= 1'h0;
      wait_stack;
      chk_rng(n, 2, 5);
      $display("wait test done");
      for (i = 0; i < 2; i = i + 1) begin
         wr(ba(`SILP_OFF_LP_CTRL), i, 4'h1);
         @(posedge aclk);
         req_stop <= 1'h1;
         @(posedge aclk);
         req_stop <= 1'h0;
         repeat (6) @(posedge aclk);
         @(negedge aclk);
         chk(internal_counter, 13'h0000);
         chk(clock_generator_output_enable, 1'h0);
         rd(ba(`SILP_OFF_LP_STAT), d, r);
         chk(d, {17'h0, `SILP_ST_STOP, 13'h0});
         @(posedge aclk);
         req_irq <= 1'h1;
         @(posedge aclk);
         req_irq <= 1'h0;
         wait_stack;
         n = n - 2 * (i ? REC_S : REC_L);
         chk_rng(n, -4, 8);
      end
      wr(ba(`SILP_OFF_LP_CTRL), 32'h2, 4'h1);
      @(negedge aclk);
      chk(watchdog_run, 1'h0);
      $display("stop test done");
      wrap_up;
   end
endmodule
